// File: rtl/cfg_flow_pkg.sv
package cfg_flow_pkg;
   // ------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------
   // Decoded instruction presented by the test access port logic
   typedef enum logic [3:0]
   {
      INSTR_NONE,
      INSTR_IO_CHAIN,
      INSTR_PARK,
      INSTR_REARM,
      INSTR_PULSE_RECONFIG,
      INSTR_PROGRAM,
      INSTR_CHECK_STATUS,
      INSTR_STARTUP,
      INSTR_OTHER
   } instr_e;

   // ------------------------------------------------------------
   // Scheme select encoding
   // ------------------------------------------------------------
   // Configuration scheme chosen by the scheme-select pins
   typedef enum logic [1:0]
   {
      SCHEME_PASSIVE_SERIAL,
      SCHEME_FAST_PASSIVE_PARALLEL,
      SCHEME_ACTIVE_SERIAL,
      SCHEME_ACTIVE_PARALLEL
   } scheme_e;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   // Clock period in picoseconds
   localparam int CLK_PERIOD_PS = 5000;
   // Width of the reconfiguration pulse that the block drives, in ns
   localparam int RECONFIG_PULSE_NS = 500;
   // Reconfiguration pulse length in cycles, rounded up
   localparam int RECONFIG_PULSE_CYC = (RECONFIG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   // Width of the pulse counter
   localparam int PULSE_CNT_W = 8;
   // Reset value of the pulse counter
   localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RST = 8'h00;
endpackage : cfg_flow_pkg

// File: rtl/reconfig_pulser.sv
`timescale 1ns/1ps
`default_nettype none
// Stretches a one-cycle trigger into a fixed reconfiguration pulse
module reconfig_pulser
(
   input wire logic clk,
   input wire logic reset,
   input wire logic trigger,
   output logic busy
);
   // Cycles remaining in the current pulse
   logic [cfg_flow_pkg::PULSE_CNT_W-1:0] count_ff;
   logic [cfg_flow_pkg::PULSE_CNT_W-1:0] nxt_count;
   // Pulse length at counter width
   wire logic [cfg_flow_pkg::PULSE_CNT_W-1:0] pulse_len;

   assign pulse_len = cfg_flow_pkg::PULSE_CNT_W'(cfg_flow_pkg::RECONFIG_PULSE_CYC);
   // Reload on trigger, else count down to zero
   assign nxt_count = trigger ? pulse_len
      : (count_ff != cfg_flow_pkg::PULSE_CNT_RST) ? count_ff - 8'h01 : count_ff;

   // ------------------------------------------------------------
   // Counter register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
         count_ff <= cfg_flow_pkg::PULSE_CNT_RST;
      else
         count_ff <= nxt_count;
   end

   assign busy = (count_ff != cfg_flow_pkg::PULSE_CNT_RST);
endmodule : reconfig_pulser
`default_nettype wire

// File: rtl/jtag_config_instruction_flow.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: I/O chain instruction reloads shift chain
// R2: Host reconfigures after interrupted testing
// R3: No I/O chain during reconfig low
// R4: Host waits 230 us before I/O chain
// R5: Power-up wait 230 us or status
// R6: Host pairs park with I/O chain
// R7: I/O chain never holds status low
// R8: I/O chain tri-states all user pins
// R9: Host parks before later program load
// R10: Program success to user re-engages controller
// R11: Passive reconfig needs no parking
// R12: Host re-arms after failed program load
// R13: Re-arm also triggers reconfiguration
// R14: Park idles controller chosen by scheme
// R15: Parked controller idle, still sees success
// R16: Host parks before programming active schemes
// R17: Park ignored in passive schemes
// R18: Program, startup, reset strictly ordered
// R19: After startup, TAP reset or instruction
// R20: Passive re-arm acts as pulse-reconfig
// R21: Serial scheme TAP reset re-engages controller
// R22: Flow state flags out-of-order instructions
module jtag_config_instruction_flow
(
   input wire logic clk,
   input wire logic reset,
   input wire cfg_flow_pkg::instr_e instr,
   input wire logic instr_valid,
   input wire logic tap_reset,
   input wire cfg_flow_pkg::scheme_e scheme_select,
   input wire logic reconfig_pin_n,
   input wire logic program_done,
   output logic io_chain_reload,
   output logic user_io_tristate,
   output logic serial_parked,
   output logic parallel_parked,
   output logic reconfig_req,
   output logic reconfig_pin_disable,
   output logic config_status_n,
   output logic order_error
);
   // ------------------------------------------------------------
   // Flow state
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      FLOW_IDLE,
      FLOW_IO_CHAIN,
      FLOW_LOADED,
      FLOW_STARTED
   } flow_e;

   flow_e flow_ff; // Current programming flow phase
   flow_e nxt_flow;
   logic serial_parked_ff; // Serial controller parked
   logic parallel_parked_ff; // Parallel controller parked
   logic io_active_ff; // I/O chain instruction executing
   logic pin_disable_ff; // Reconfiguration pin ignored
   logic order_error_ff; // Sticky order violation
   logic reload_ff; // Shift chain reload strobe
   logic pulser_busy; // Reconfiguration pulse running

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic is_active_scheme;
   wire logic do_io;
   wire logic do_park;
   wire logic do_rearm;
   wire logic do_pulse;
   wire logic do_program;
   wire logic do_startup;
   wire logic do_other;
   wire logic reengage;
   wire logic trig_reconfig;
   wire logic bad_order;

   assign is_active_scheme = (scheme_select == cfg_flow_pkg::SCHEME_ACTIVE_SERIAL)
      || (scheme_select == cfg_flow_pkg::SCHEME_ACTIVE_PARALLEL);
   assign do_io = instr_valid && (instr == cfg_flow_pkg::INSTR_IO_CHAIN);
   assign do_park = instr_valid && (instr == cfg_flow_pkg::INSTR_PARK)
      && is_active_scheme; // R17
   assign do_rearm = instr_valid && (instr == cfg_flow_pkg::INSTR_REARM);
   assign do_pulse = instr_valid && (instr == cfg_flow_pkg::INSTR_PULSE_RECONFIG);
   assign do_program = instr_valid && (instr == cfg_flow_pkg::INSTR_PROGRAM);
   assign do_startup = instr_valid && (instr == cfg_flow_pkg::INSTR_STARTUP);
   assign do_other = instr_valid && !do_program && !do_startup
      && (instr != cfg_flow_pkg::INSTR_CHECK_STATUS);
   // Successful program load reaching user mode, or serial TAP reset
   assign reengage = (program_done && (flow_ff == FLOW_STARTED)) // R10 R15
      || (tap_reset && serial_parked_ff); // R21
   // Re-arm restarts configuration in every scheme
   assign trig_reconfig = do_pulse || do_rearm; // R13 R20
   // Startup without load, load in active scheme while unparked, or I/O chain while pin low
   assign bad_order = (do_startup && (flow_ff != FLOW_LOADED))
      || (do_program && is_active_scheme && !serial_parked_ff && !parallel_parked_ff)
      || (do_io && !reconfig_pin_n); // R22

   // ------------------------------------------------------------
   // Flow next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_flow = flow_ff;
      case (flow_ff)
         FLOW_IDLE:
            // Enter I/O chain phase or program load
            if (do_program)
               nxt_flow = FLOW_LOADED;
            else if (do_io)
               nxt_flow = FLOW_IO_CHAIN;
         FLOW_IO_CHAIN:
            // Leave on load, reconfig or TAP reset
            if (do_program)
               nxt_flow = FLOW_LOADED;
            else if (trig_reconfig || tap_reset)
               nxt_flow = FLOW_IDLE;
         FLOW_LOADED:
            // Startup follows load
            if (do_startup)
               nxt_flow = FLOW_STARTED; // R18
            else if (tap_reset || trig_reconfig)
               nxt_flow = FLOW_IDLE;
         FLOW_STARTED:
            // TAP reset, program done, or any instruction other than program, startup or status check closes the flow
            if (tap_reset || do_other || program_done)
               nxt_flow = FLOW_IDLE; // R19
         default:
            nxt_flow = FLOW_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Flow state and sticky error
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flow_ff <= FLOW_IDLE;
         order_error_ff <= 1'b0;
      end
      else
      begin
         flow_ff <= nxt_flow;
         order_error_ff <= order_error_ff || bad_order; // R22
      end
   end

   // Parking of the selected active controller
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         serial_parked_ff <= 1'b0;
         parallel_parked_ff <= 1'b0;
      end
      else if (do_park)
      begin
         serial_parked_ff <= (scheme_select == cfg_flow_pkg::SCHEME_ACTIVE_SERIAL); // R14
         parallel_parked_ff <= (scheme_select == cfg_flow_pkg::SCHEME_ACTIVE_PARALLEL); // R14
      end
      else if (reengage || do_rearm)
      begin
         serial_parked_ff <= 1'b0; // R10
         parallel_parked_ff <= (program_done && (flow_ff == FLOW_STARTED)) || do_rearm
            ? 1'b0 : parallel_parked_ff; // R10
      end
   end

   // I/O chain execution and reload strobe
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         io_active_ff <= 1'b0;
         reload_ff <= 1'b0;
      end
      else
      begin
         reload_ff <= do_io; // R1
         if (do_io)
            io_active_ff <= 1'b1;
         else if (instr_valid || tap_reset)
            io_active_ff <= 1'b0;
      end
   end

   // Reconfiguration pin disabled after a re-arm in passive schemes
   always_ff @(posedge clk)
   begin
      if (reset)
         pin_disable_ff <= 1'b0;
      else if (do_rearm && !is_active_scheme)
         pin_disable_ff <= 1'b1; // R20
      else if (do_pulse)
         pin_disable_ff <= 1'b0;
   end

   // ------------------------------------------------------------
   // Reconfiguration pulse
   // ------------------------------------------------------------
   reconfig_pulser u_pulser
   (
      .clk(clk),
      .reset(reset),
      .trigger(trig_reconfig), // R13
      .busy(pulser_busy)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign io_chain_reload = reload_ff;
   assign user_io_tristate = io_active_ff; // R8
   assign serial_parked = serial_parked_ff;
   assign parallel_parked = parallel_parked_ff;
   assign reconfig_req = pulser_busy;
   assign reconfig_pin_disable = pin_disable_ff;
   // Status low only during reconfiguration, never from the I/O chain
   assign config_status_n = !pulser_busy; // R7
   assign order_error = order_error_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_io_issue;
      do_io;
   endsequence

   sequence s_io_effect;
      io_chain_reload && user_io_tristate;
   endsequence

   AST_IO_RELOAD: assert property (@(posedge clk) disable iff (reset) // R1
      s_io_issue |=> s_io_effect)
      else $error("I/O chain reload missing");

   AST_IO_TRISTATE: assert property (@(posedge clk) disable iff (reset) // R8
      do_io ##1 !instr_valid && !tap_reset |=> user_io_tristate)
      else $error("User pins not tri-stated");

   AST_STATUS_NOT_HELD: assert property (@(posedge clk) disable iff (reset) // R7
      do_io && !reconfig_req |=> config_status_n)
      else $error("Status held low by I/O chain");

   AST_PARK_SERIAL: assert property (@(posedge clk) disable iff (reset) // R14
      do_park && scheme_select == cfg_flow_pkg::SCHEME_ACTIVE_SERIAL
      |=> serial_parked && !parallel_parked)
      else $error("Serial controller not parked");

   AST_PASSIVE_PARK: assert property (@(posedge clk) disable iff (reset) // R17
      instr_valid && instr == cfg_flow_pkg::INSTR_PARK && !is_active_scheme
      && !reengage && !do_rearm |=> $stable(serial_parked) && $stable(parallel_parked))
      else $error("Park acted in passive scheme");

   AST_REENGAGE: assert property (@(posedge clk) disable iff (reset) // R10
      program_done && flow_ff == FLOW_STARTED && !do_park |=> !serial_parked && !parallel_parked)
      else $error("Controller not re-engaged");

   AST_TAP_REENGAGE: assert property (@(posedge clk) disable iff (reset) // R21
      tap_reset && serial_parked && !do_park |=> !serial_parked)
      else $error("Serial controller not re-engaged on TAP reset");

   AST_REARM_RECONFIG: assert property (@(posedge clk) disable iff (reset) // R13
      do_rearm |=> reconfig_req [*8])
      else $error("Re-arm did not start reconfiguration");

   AST_PASSIVE_REARM: assert property (@(posedge clk) disable iff (reset) // R20
      do_rearm && !is_active_scheme |=> reconfig_pin_disable && !config_status_n)
      else $error("Passive re-arm not handled");

   AST_ORDER_FLAG: assert property (@(posedge clk) disable iff (reset) // R22
      do_startup && flow_ff != FLOW_LOADED |=> order_error)
      else $error("Out of order startup not flagged");
endmodule : jtag_config_instruction_flow
`default_nettype wire

// File: bench/jtag_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host side of the test access port
// ------------------------------------------------------------
// Issues decoded instructions one at a time and keeps host timing
module jtag_host_model
#(
   // Quiet time of 230 us at a 5 ns clock
   parameter int WAIT_CYC = 46000
)
(
   input wire logic clk,
   input wire logic reconfig_pin_n,
   output cfg_flow_pkg::instr_e instr,
   output logic instr_valid,
   output logic tap_reset
);
   // Cycles since power-up, pin release or a restarting instruction
   int quiet_cnt = 0;

   // Idle levels at time zero
   initial
   begin
      instr = cfg_flow_pkg::INSTR_NONE;
      instr_valid = 1'b0;
      tap_reset = 1'b0;
   end

   // Quiet time, held at zero while the pin is low or a restart is taken
   always @(posedge clk)
   begin
      if (!reconfig_pin_n)
         quiet_cnt <= 0;
      else if (instr_valid && (instr == cfg_flow_pkg::INSTR_PULSE_RECONFIG
         || instr == cfg_flow_pkg::INSTR_REARM))
         quiet_cnt <= 0;
      else
         quiet_cnt <= quiet_cnt + 1;
   end

   // One instruction, returns on the edge that takes it
   task automatic issue(input cfg_flow_pkg::instr_e code);
      if (code == cfg_flow_pkg::INSTR_IO_CHAIN)
         while (!reconfig_pin_n || quiet_cnt < WAIT_CYC) @(posedge clk);
      @(posedge clk);
      instr <= code;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      // Released lines do not keep the last code
      instr <= cfg_flow_pkg::instr_e'(~code);
   endtask : issue

   // Hold-off after an instruction that restarts configuration
   task automatic settle();
      while (quiet_cnt < WAIT_CYC) @(posedge clk);
   endtask : settle

   // TAP reset, also ends a startup flow
   task automatic tap();
      @(posedge clk);
      tap_reset <= 1'b1;
      @(posedge clk);
      tap_reset <= 1'b0;
   endtask : tap
endmodule : jtag_host_model
`default_nettype wire

// File: bench/jtag_config_instruction_flow_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module jtag_config_instruction_flow_tb;
   logic clk;
   logic reset;
   cfg_flow_pkg::scheme_e scheme_select;
   logic reconfig_pin_n;
   logic program_done;
   cfg_flow_pkg::instr_e instr;
   logic instr_valid;
   logic tap_reset;
   logic io_chain_reload;
   logic user_io_tristate;
   logic serial_parked;
   logic parallel_parked;
   logic reconfig_req;
   logic reconfig_pin_disable;
   logic config_status_n;
   logic order_error;
   // Tallies
   int fail_count = 0;
   int checks = 0;

   jtag_config_instruction_flow jtag_config_instruction_flow_i
   (
      .clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
      .tap_reset(tap_reset), .scheme_select(scheme_select),
      .reconfig_pin_n(reconfig_pin_n), .program_done(program_done),
      .io_chain_reload(io_chain_reload), .user_io_tristate(user_io_tristate),
      .serial_parked(serial_parked), .parallel_parked(parallel_parked),
      .reconfig_req(reconfig_req), .reconfig_pin_disable(reconfig_pin_disable),
      .config_status_n(config_status_n), .order_error(order_error)
   );

   jtag_host_model jtag_host_model_i
   (
      .clk(clk), .reconfig_pin_n(reconfig_pin_n), .instr(instr),
      .instr_valid(instr_valid), .tap_reset(tap_reset)
   );

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   // Move the scheme pins between edges of activity
   task automatic set_scheme(input cfg_flow_pkg::scheme_e s);
      @(posedge clk);
      scheme_select <= s;
   endtask : set_scheme

   // Length of the generated reconfiguration pulse
   task automatic pulse_len();
      int cnt;
      cnt = 0;
      while (reconfig_req === 1'b1 && cnt < 200)
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
      check("reconfig_len", cnt[7:0], 8'(cfg_flow_pkg::RECONFIG_PULSE_CYC));
   endtask : pulse_len

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_io_chain();
      // Pin pulsed low 500 ns, then chain reload after the wait
      @(posedge clk);
      reconfig_pin_n <= 1'b0;
      repeat (100) @(posedge clk);
      reconfig_pin_n <= 1'b1;
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_IO_CHAIN);
      #1;
      check("io_chain_reload", io_chain_reload, 8'h01);
      check("user_io_tristate", user_io_tristate, 8'h01);
      @(posedge clk);
      #1;
      check("io_chain_reload", io_chain_reload, 8'h00);
      check("user_io_tristate", user_io_tristate, 8'h01);
      check("config_status_n", config_status_n, 8'h01);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_OTHER);
      #1;
      check("user_io_tristate", user_io_tristate, 8'h00);
   endtask : t_io_chain

   task automatic t_park_rearm();
      // Every scheme: park, then re-arm
      for (int s = 0; s < 4; s++)
      begin
         set_scheme(cfg_flow_pkg::scheme_e'(s));
         jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PARK);
         #1;
         check("serial_parked", serial_parked, 8'(s == 2));
         check("parallel_parked", parallel_parked, 8'(s == 3));
         jtag_host_model_i.issue(cfg_flow_pkg::INSTR_REARM);
         #1;
         check("serial_parked", serial_parked, 8'h00);
         check("parallel_parked", parallel_parked, 8'h00);
         check("config_status_n", config_status_n, 8'h00);
         check("reconfig_pin_disable", reconfig_pin_disable, 8'(s < 2));
         pulse_len();
         if (s < 2)
         begin
            jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PULSE_RECONFIG);
            #1;
            check("reconfig_pin_disable", reconfig_pin_disable, 8'h00);
            pulse_len();
         end
      end
      // Quiet time after the last restart before anything else
      jtag_host_model_i.settle();
   endtask : t_park_rearm

   task automatic t_program();
      // Parked serial controller, full program flow
      set_scheme(cfg_flow_pkg::SCHEME_ACTIVE_SERIAL);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PARK);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PROGRAM);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_CHECK_STATUS);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_STARTUP);
      #1;
      check("serial_parked", serial_parked, 8'h01);
      @(posedge clk);
      program_done <= 1'b1;
      @(posedge clk);
      program_done <= 1'b0;
      #1;
      check("serial_parked", serial_parked, 8'h00);
      check("order_error", order_error, 8'h00);
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_OTHER);
      // TAP reset releases a parked serial controller
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PARK);
      jtag_host_model_i.tap();
      #1;
      check("serial_parked", serial_parked, 8'h00);
   endtask : t_program

   task automatic t_order();
      // Program in an active scheme with no park
      jtag_host_model_i.issue(cfg_flow_pkg::INSTR_PROGRAM);
      #1;
      check("order_error", order_error, 8'h01);
      repeat (3) @(posedge clk);
      #1;
      check("order_error", order_error, 8'h01);
   endtask : t_order

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      scheme_select = cfg_flow_pkg::SCHEME_PASSIVE_SERIAL;
      reconfig_pin_n = 1'b1;
      program_done = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      #1;
      check("config_status_n", config_status_n, 8'h01);
      check("reconfig_req", reconfig_req, 8'h00);
      check("order_error", order_error, 8'h00);
      t_io_chain();
      t_park_rearm();
      t_program();
      t_order();
      close_out();
   end

   // Hang guard, beyond the two quiet waits of the expected run
   initial
   begin
      #510000;
      fail_count++;
      close_out();
   end
endmodule : jtag_config_instruction_flow_tb
`default_nettype wire
